/* hw/swc_pkg.sv */
// Constants and types for the single-wire command port
// What this block does
// [RQ1] The line is open-drain on the device side: the device only ever pulls low or releases.
// [RQ2] Every transaction opens with a command byte that selects a store or a fetch of one register.
// [RQ3] Command and data are eight-bit sequences at no more than 333 bits per second.
// [RQ4] Every command and data byte travels least-significant bit first.
// [RQ5] Any low period of the break length or longer is taken as a line reset; a break that completes while the device drives the line low is ignored.
// [RQ6] After a line reset a command is accepted only once the line has been high for the recovery time.
// [RQ7] Each bit opens with a falling edge and a low start period driven by the transmitter.
// [RQ8] The bit level is valid by the setup time after the falling edge and held for the hold time.
// [RQ9] The transmitter returns the line high by the stop-setup time and keeps it high to stop-valid.
// [RQ10] The command byte is loaded only after eight valid bits and can never be read back.
// [RQ11] Command bit 7 set means store the next byte; clear means send the addressed register.
// [RQ12] The low seven command bits are the register address.
// [RQ13] A data byte written to an invalid address is dropped and no register changes.
// [RQ14] After a read command the device waits out the last bit then sends eight bits in host framing.
package swc_pkg;
   localparam int CLK_HZ = 25000000;
   // Times in microseconds
   localparam int BREAK_US = 200;
   localparam int BREAK_RECOVERY_US = 50;
   localparam int START_LOW_US = 60;
   localparam int DATA_SETUP_US = 90;
   localparam int DATA_HOLD_US = 60;
   localparam int STOP_SETUP_US = 160;
   localparam int STOP_VALID_US = 3000;
   localparam int US_CYC = CLK_HZ / 1000000;
   localparam int BREAK_CYC = BREAK_US * US_CYC;
   localparam int RECOVERY_CYC = BREAK_RECOVERY_US * US_CYC;
   localparam int START_LOW_CYC = START_LOW_US * US_CYC;
   localparam int SAMPLE_CYC = (DATA_SETUP_US + DATA_HOLD_US / 2) * US_CYC;
   localparam int DATA_END_CYC = (DATA_SETUP_US + DATA_HOLD_US) * US_CYC;
   localparam int STOP_CYC = STOP_SETUP_US * US_CYC;
   localparam int BIT_CYC = STOP_VALID_US * US_CYC;
   localparam int CNT_W = 20;
   // Command byte layout
   localparam int CMD_DIR_BIT = 7;
   localparam int ADDR_W = 7;
   localparam int BYTE_W = 8;
   localparam logic [7:0] CMD_RESET = 8'h00;
   typedef enum logic [2:0] {
      SWC_RECOVER, SWC_CMD, SWC_WDATA, SWC_TX_WAIT, SWC_TX
   } swc_state_t;
endpackage

/* hw/swc_bit_rx.sv */
// Bit-frame receiver: break detection and bit sampling on the line
`timescale 1ns/100ps
module swc_bit_rx #(
   parameter int US_CYC = swc_pkg::US_CYC
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // Line
   input wire logic line_in,
   // Results
   output logic bit_valid_out,
   output logic bit_value_out,
   output logic break_out
);
   typedef struct packed {
      logic line_prev;
      logic [swc_pkg::CNT_W-1:0] low_cnt;
      logic [swc_pkg::CNT_W-1:0] frame_cnt;
      logic in_frame;
      logic bit_valid;
      logic bit_value;
      logic brk;
   } swc_rx_t;
   swc_rx_t s_q, s_d;
   localparam int BREAK_CYC = swc_pkg::BREAK_US * US_CYC;
   localparam int SAMPLE_CYC = (swc_pkg::DATA_SETUP_US + swc_pkg::DATA_HOLD_US / 2) * US_CYC;
   always_comb begin
      s_d = s_q;
      s_d.line_prev = line_in;
      s_d.bit_valid = 1'b0;
      s_d.brk = 1'b0;
      if (!line_in) begin
         if (s_q.low_cnt != swc_pkg::CNT_W'(BREAK_CYC)) begin
            s_d.low_cnt = s_q.low_cnt + 1'b1;
         end
         if (s_q.low_cnt == swc_pkg::CNT_W'(BREAK_CYC - 1)) begin
            s_d.brk = 1'b1;  // [RQ5]
            s_d.in_frame = 1'b0;
         end
      end else begin
         s_d.low_cnt = '0;
      end
      if (s_q.line_prev && !line_in) begin
         s_d.in_frame = 1'b1;  // [RQ7]
         s_d.frame_cnt = '0;
      end else if (s_q.in_frame) begin
         s_d.frame_cnt = s_q.frame_cnt + 1'b1;
         if (s_q.frame_cnt == swc_pkg::CNT_W'(SAMPLE_CYC)) begin
            s_d.bit_valid = 1'b1;  // [RQ8]
            s_d.bit_value = line_in;
            s_d.in_frame = 1'b0;
         end
      end
   end
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s_q <= '{line_prev: 1'b1, default: '0};
      end else begin
         s_q <= s_d;
      end
   end
   assign bit_valid_out = s_q.bit_valid;
   assign bit_value_out = s_q.bit_value;
   assign break_out = s_q.brk;
endmodule

/* hw/swc_port.sv */
// Top of the single-wire command port, device side
`timescale 1ns/100ps
module swc_port #(
   // Clock cycles per microsecond of line timing
   parameter int US_CYC = swc_pkg::US_CYC
) (
   // Clock and reset
   input wire logic CORE_CLK_IN,
   input wire logic RESET_N_IN,
   // Serial line, open drain
   input wire logic LINE_IN,
   output logic LINE_OUT,
   output logic LINE_OE_OUT,
   // Register file side
   output logic REG_WR_OUT,
   output logic [6:0] REG_ADDR_OUT,
   output logic [7:0] REG_WDATA_OUT,
   input wire logic [7:0] REG_RDATA_IN,
   input wire logic REG_ADDR_OK_IN,
   // Status
   output logic BUSY_OUT
);
   logic rx_valid, rx_value, rx_break;
   typedef struct packed {
      swc_pkg::swc_state_t st;
      logic [swc_pkg::CNT_W-1:0] cnt;
      logic [2:0] nbit;
      logic [7:0] shift;
      logic [7:0] command_byte;
      logic [7:0] tx_byte;
      logic wr;
      logic [6:0] addr;
      logic [7:0] wdata;
      logic oe;
      logic busy;
   } swc_top_t;
   swc_top_t s_q, s_d;
   localparam int RECOVERY_CYC = swc_pkg::BREAK_RECOVERY_US * US_CYC;
   localparam int START_LOW_CYC = swc_pkg::START_LOW_US * US_CYC;
   localparam int SAMPLE_CYC = (swc_pkg::DATA_SETUP_US + swc_pkg::DATA_HOLD_US / 2) * US_CYC;
   localparam int DATA_END_CYC = (swc_pkg::DATA_SETUP_US + swc_pkg::DATA_HOLD_US) * US_CYC;
   localparam int BIT_CYC = swc_pkg::STOP_VALID_US * US_CYC;
   swc_bit_rx #(
      .US_CYC(US_CYC)
   ) u_rx (
      .clk_in(CORE_CLK_IN),
      .reset_n_in(RESET_N_IN),
      .line_in(LINE_IN),
      .bit_valid_out(rx_valid),
      .bit_value_out(rx_value),
      .break_out(rx_break)
   );
   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d = s_q;
      s_d.wr = 1'b0;
      s_d.busy = (s_q.st != swc_pkg::SWC_CMD) || (s_q.nbit != 3'h0);
      unique case (s_q.st)
         swc_pkg::SWC_RECOVER: begin
            // Line must rest high before a command counts
            if (!LINE_IN) begin
               s_d.cnt = '0;
            end else if (s_q.cnt == swc_pkg::CNT_W'(RECOVERY_CYC - 1)) begin
               s_d.st = swc_pkg::SWC_CMD;  // [RQ6]
               s_d.nbit = '0;
            end else begin
               s_d.cnt = s_q.cnt + 1'b1;
            end
         end
         swc_pkg::SWC_CMD, swc_pkg::SWC_WDATA: begin
            if (rx_valid) begin
               s_d.shift = {rx_value, s_q.shift[7:1]};  // [RQ4]
               s_d.nbit = s_q.nbit + 1'b1;
               if (s_q.nbit == 3'h7) begin  // [RQ3]
                  if (s_q.st == swc_pkg::SWC_CMD) begin
                     s_d.command_byte = {rx_value, s_q.shift[7:1]};  // [RQ10] [RQ2]
                     s_d.addr = s_d.command_byte[swc_pkg::ADDR_W-1:0];  // [RQ12]
                     s_d.cnt = '0;
                     s_d.st = s_d.command_byte[swc_pkg::CMD_DIR_BIT] ?  // [RQ11]
                        swc_pkg::SWC_WDATA : swc_pkg::SWC_TX_WAIT;
                  end else begin
                     s_d.wdata = {rx_value, s_q.shift[7:1]};
                     s_d.wr = REG_ADDR_OK_IN;  // [RQ13]
                     s_d.st = swc_pkg::SWC_CMD;
                  end
               end
            end
         end
         swc_pkg::SWC_TX_WAIT: begin
            // Let the host's last bit run to its stop-valid end
            s_d.cnt = s_q.cnt + 1'b1;
            if (s_q.cnt == swc_pkg::CNT_W'(BIT_CYC - SAMPLE_CYC)) begin
               s_d.tx_byte = REG_RDATA_IN;  // [RQ14]
               s_d.cnt = '0;
               s_d.nbit = '0;
               s_d.st = swc_pkg::SWC_TX;
            end
         end
         swc_pkg::SWC_TX: begin
            s_d.cnt = s_q.cnt + 1'b1;
            if (s_q.cnt < swc_pkg::CNT_W'(START_LOW_CYC)) begin
               s_d.oe = 1'b1;  // [RQ7]
            end else if (s_q.cnt < swc_pkg::CNT_W'(DATA_END_CYC)) begin
               s_d.oe = !s_q.tx_byte[s_q.nbit];  // [RQ8] [RQ4]
            end else begin
               s_d.oe = 1'b0;  // [RQ9]
            end
            if (s_q.cnt == swc_pkg::CNT_W'(BIT_CYC - 1)) begin
               s_d.cnt = '0;
               s_d.nbit = s_q.nbit + 1'b1;
               if (s_q.nbit == 3'h7) begin
                  s_d.st = swc_pkg::SWC_CMD;
                  s_d.nbit = '0;
               end
            end
         end
      endcase
      if (rx_break && !s_q.oe) begin
         s_d.st = swc_pkg::SWC_RECOVER;  // [RQ5]
         s_d.cnt = '0;
         s_d.oe = 1'b0;
         s_d.nbit = '0;
      end
   end
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         s_q <= '{st: swc_pkg::SWC_RECOVER, command_byte: swc_pkg::CMD_RESET, default: '0};
      end else begin
         s_q <= s_d;
      end
   end
   assign LINE_OUT = 1'b0;  // [RQ1]
   assign LINE_OE_OUT = s_q.oe;
   assign REG_WR_OUT = s_q.wr;
   assign REG_ADDR_OUT = s_q.addr;
   assign REG_WDATA_OUT = s_q.wdata;
   assign BUSY_OUT = s_q.busy;
endmodule

/* sim/swc_port_monitor.sv */
// Assertion checker for the single-wire command port
`timescale 1ns/100ps
module swc_port_monitor #(
   parameter int US_CYC = swc_pkg::US_CYC
) (
   // Watched ports
   input wire logic CORE_CLK_IN,
   input wire logic RESET_N_IN,
   input wire logic LINE_OUT,
   input wire logic LINE_OE_OUT,
   input wire logic REG_WR_OUT,
   input wire logic [6:0] REG_ADDR_OUT,
   input wire logic REG_ADDR_OK_IN,
   input wire logic BUSY_OUT
);
   localparam int OE_MAX = (swc_pkg::DATA_SETUP_US + swc_pkg::DATA_HOLD_US) * US_CYC + 2;
   logic [12:0] oe_cnt_q;
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RESET_N_IN);
   ////////////////////////////////////////////////////////////
   always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         oe_cnt_q <= 13'h0;
      end else begin
         oe_cnt_q <= LINE_OE_OUT ? oe_cnt_q + 13'h1 : 13'h0;
      end
   end
   sequence s_tx_open;
      $rose(LINE_OE_OUT);
   endsequence
   sequence s_start_low;
      LINE_OE_OUT [*8];
   endsequence
   a_line_only_low: assert property (LINE_OUT == 1'h0) else $error("line driven high");
   a_wr_one_cycle: assert property (REG_WR_OUT |=> !REG_WR_OUT) else $error("long pulse");
   a_wr_valid_addr: assert property (REG_WR_OUT |-> $past(REG_ADDR_OK_IN))
      else $error("bad addr");
   a_wr_not_tx: assert property (REG_WR_OUT |-> !LINE_OE_OUT) else $error("write on tx");
   a_tx_when_busy: assert property (LINE_OE_OUT |-> BUSY_OUT) else $error("tx idle");
   a_wr_addr_held: assert property (REG_WR_OUT |-> $stable(REG_ADDR_OUT)) else $error("addr");
   a_tx_start_low: assert property (s_tx_open |-> s_start_low) else $error("short start");
   a_tx_stop_bound: assert property (oe_cnt_q <= OE_MAX) else $error("low too long");
endmodule

/* sim/swc_host_model.sv */
// Host processor model on the pulled-up single-wire line
`timescale 1ns/100ps
module swc_host_model #(
   parameter int US_CYC = swc_pkg::US_CYC
) (
   // Clock and device pull
   input wire logic clk_in,
   input wire logic dev_oe_in,
   // Resolved line
   output logic line_out
);
   logic host_low = 1'h0;
   assign line_out = !(host_low || dev_oe_in);
   ////////////////////////////////////////////////////////////
   task automatic hold(input int n, input logic low);
      host_low <= low;
      repeat (n) @(posedge clk_in);
   endtask
   task automatic brk();
      hold((swc_pkg::BREAK_US + 8) * US_CYC, 1'h1);
      hold((swc_pkg::BREAK_RECOVERY_US + 6) * US_CYC, 1'h0);
   endtask
   task automatic send_byte(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         hold(swc_pkg::START_LOW_US * US_CYC, 1'h1);
         hold(swc_pkg::DATA_SETUP_US * US_CYC, !b[i]);
         hold(2850 * US_CYC, 1'h0);
      end
   endtask
   task automatic recv_byte(output logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         repeat ((swc_pkg::STOP_VALID_US + 200) * US_CYC) begin
            @(posedge clk_in);
            if (!line_out) break;
         end
         repeat (105 * US_CYC) @(posedge clk_in);
         b[i] = line_out;
         repeat (80 * US_CYC) @(posedge clk_in);
      end
   endtask
endmodule

/* sim/test_swc_port.sv */
// Self-checking bench for the single-wire command port
`timescale 1ns/100ps
module test_swc_port;
   // One clock per microsecond keeps the run short
   localparam int US_CYC = 1;
   logic clk = 1'h0;
   logic rst_n, line, oe, wr, addr_ok, busy;
   logic [6:0] addr;
   logic [7:0] wdata, rdata, got;
   int wr_cnt = 0, n_fail = 0, num_checks = 0;
   swc_port #(.US_CYC(US_CYC)) i_dut (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n),
      .LINE_IN(line), .LINE_OUT(),
      .LINE_OE_OUT(oe), .REG_WR_OUT(wr), .REG_ADDR_OUT(addr), .REG_WDATA_OUT(wdata),
      .REG_RDATA_IN(rdata), .REG_ADDR_OK_IN(addr_ok), .BUSY_OUT(busy));
   swc_host_model #(.US_CYC(US_CYC)) i_host (.clk_in(clk), .dev_oe_in(oe), .line_out(line));
   ////////////////////////////////////////////////////////////
   initial forever #20 clk = !clk;
   always @(posedge clk) if (wr) wr_cnt <= wr_cnt + 1;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic t_line_reset();
      i_host.brk();
      check({7'h00, busy}, 8'h00);
      $display("line_reset done");
   endtask
   task automatic t_write_ok();
      addr_ok <= 1'h1;
      i_host.send_byte(8'h83);
      i_host.send_byte(8'h1E);
      check(8'(wr_cnt), 8'h01);
      check({1'h0, addr}, 8'h03);
      check(wdata, 8'h1E);
      $display("write_ok done");
   endtask
   task automatic t_write_bad();
      addr_ok <= 1'h0;
      i_host.send_byte(8'hFF);
      i_host.send_byte(8'h3C);
      check(8'(wr_cnt), 8'h01);
      check({1'h0, addr}, 8'h7F);
      $display("write_bad done");
   endtask
   task automatic t_read();
      rdata <= 8'h96;
      i_host.send_byte(8'h05);
      i_host.recv_byte(got);
      check(got, 8'h96);
      check({1'h0, addr}, 8'h05);
      $display("read done");
   endtask
   initial begin
      rst_n = 1'h0;
      addr_ok = 1'h0;
      rdata = 8'h00;
      repeat (6) @(posedge clk);
      rst_n <= 1'h1;
      t_line_reset();
      t_write_ok();
      t_write_bad();
      t_read();
      complete_run();
   end
   initial begin
      repeat (60 * swc_pkg::STOP_VALID_US * US_CYC) @(posedge clk);
      n_fail++;
      complete_run();
   end
endmodule
bind swc_port swc_port_monitor #(.US_CYC(US_CYC)) i_mon (.CORE_CLK_IN(CORE_CLK_IN),
   .RESET_N_IN(RESET_N_IN),
   .LINE_OUT(LINE_OUT), .LINE_OE_OUT(LINE_OE_OUT), .REG_WR_OUT(REG_WR_OUT),
   .REG_ADDR_OUT(REG_ADDR_OUT), .REG_ADDR_OK_IN(REG_ADDR_OK_IN), .BUSY_OUT(BUSY_OUT));
